// ### hw/orsa_align_if.sv
`timescale 1ns/10ps
`default_nettype none

interface orsa_align_if;
  orsa_pkg::orsa_ratio_t ratio;
  logic sysref_sync;
  logic lmfc_pulse;

  modport core (output ratio, output sysref_sync, input lmfc_pulse);
  modport align (input ratio, input sysref_sync, output lmfc_pulse);
endinterface

`default_nettype wire

// ### hw/orsa_defines.svh
`ifndef ORSA_DEFINES_SVH
`define ORSA_DEFINES_SVH

// divider setting codes on input_clock_divide_ratio_in
`define ORSA_DIV1 2'h0
`define ORSA_DIV2 2'h1
`define ORSA_DIV4 2'h2

// input clock cycles per frame, less one, for each divider
`define ORSA_FRAME_LAST_DIV1 2'h0
`define ORSA_FRAME_LAST_DIV2 2'h1
`define ORSA_FRAME_LAST_DIV4 2'h3

// flag assert delay in frame cycles
`define ORSA_ASSERT_FRAMES 8
// width of the release delay setting (0 to 15 extra frames)
`define ORSA_REL_W 4

// system reference to multiframe boundary, input clock cycles
`define ORSA_LMFC_DIV1 5'h04
`define ORSA_LMFC_DIV2 5'h0a
`define ORSA_LMFC_DIV4 5'h12
// cycles already spent in the pin synchroniser and edge detector
`define ORSA_SYNC_LAT 5'h03
`define ORSA_LMFC_CNT_W 5

`endif

// ### hw/orsa_pkg.sv
`include "orsa_defines.svh"

package orsa_pkg;
  typedef logic [1:0] orsa_ratio_t;
  typedef logic [`ORSA_REL_W-1:0] orsa_rel_t;
  typedef logic [`ORSA_LMFC_CNT_W-1:0] orsa_lmfc_cnt_t;

  typedef enum logic [1:0] {
    ORSA_FLAG_CLEAR = 2'b01,
    ORSA_FLAG_HELD = 2'b10
  } orsa_flag_state_e;
endpackage

// ### hw/orsa_sysref_align.sv
`timescale 1ns/10ps
`default_nettype none
`include "orsa_defines.svh"

module orsa_sysref_align (
  input wire logic clk_in,
  input wire logic rst_n_in,
  orsa_align_if.align link
);
  typedef struct packed {
    logic sysref_prev;
    orsa_pkg::orsa_lmfc_cnt_t cnt;
    logic pulse;
  } orsa_align_s;

  orsa_align_s st;
  orsa_align_s next_st;

  function automatic orsa_pkg::orsa_lmfc_cnt_t lmfc_delay(input orsa_pkg::orsa_ratio_t r);
    case (r)
      `ORSA_DIV1: lmfc_delay = `ORSA_LMFC_DIV1;
      `ORSA_DIV2: lmfc_delay = `ORSA_LMFC_DIV2;
      default: lmfc_delay = `ORSA_LMFC_DIV4;
    endcase
  endfunction

  always_comb
  begin
    next_st = st;
    next_st.sysref_prev = link.sysref_sync;
    next_st.pulse = 1'b0;
    if (link.sysref_sync && !st.sysref_prev)
    begin
      next_st.cnt = lmfc_delay(link.ratio) - `ORSA_SYNC_LAT;
    end
    else if (st.cnt != '0)
    begin
      next_st.cnt = st.cnt - 1'b1;
      next_st.pulse = (st.cnt == `ORSA_LMFC_CNT_W'(1));
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign link.lmfc_pulse = st.pulse;

  chk_lmfc_no_early: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (link.sysref_sync && !st.sysref_prev && link.ratio == `ORSA_DIV1)
      |=> !st.pulse ##1 st.pulse)
    else $error("multiframe boundary misplaced at divide by one");
endmodule

`default_nettype wire

// ### hw/orsa_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "orsa_defines.svh"
// How it works
// - an out-of-range sample raises the flag exactly 8 frame cycles after it was taken.
// - the release delay counts from the first in-range sample and is set by a config input.
// - at the minimum setting the flag drops 8 frame cycles after that in-range sample.
// - at the maximum setting the flag drops 15 frame cycles later than that.
// - the shared pin carries the flag only while over-range output mode is selected.
// - the multiframe boundary follows a latched reference by 4, 10 or 18 input clocks.
// - one frame cycle is one sample period, the input clock divided by the ratio.
// - outside over-range mode the shared pin is driven only during a register read.

module orsa_top (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [1:0] input_clock_divide_ratio_in,
  input wire logic sample_over_range_in,
  input wire logic [`ORSA_REL_W-1:0] release_delay_in,
  input wire logic overrange_mode_in,
  input wire logic readback_active_in,
  input wire logic readback_data_in,
  input wire logic sysref_in,
  output logic over_range_flag_out,
  output logic shared_readback_overrange_pin_out,
  output logic shared_readback_overrange_pin_oe_out,
  output logic lmfc_boundary_out
);
  typedef struct packed {
    logic [1:0] frame_cnt;
    logic [`ORSA_ASSERT_FRAMES-2:0] line;
    orsa_pkg::orsa_flag_state_e flag_st;
    orsa_pkg::orsa_rel_t rel_cnt;
    logic sysref_s1;
    logic sysref_s2;
    logic pin_out;
    logic pin_oe;
  } orsa_core_s;

  orsa_core_s st;
  orsa_core_s next_st;
  logic tick;
  logic tail;
  logic held;

  orsa_align_if align_link ();

  function automatic logic [1:0] frame_last(input orsa_pkg::orsa_ratio_t r);
    case (r)
      `ORSA_DIV1: frame_last = `ORSA_FRAME_LAST_DIV1;
      `ORSA_DIV2: frame_last = `ORSA_FRAME_LAST_DIV2;
      default: frame_last = `ORSA_FRAME_LAST_DIV4;
    endcase
  endfunction

  assign tick = (st.frame_cnt == '0);
  assign tail = st.line[`ORSA_ASSERT_FRAMES-2];
  assign held = (st.flag_st == orsa_pkg::ORSA_FLAG_HELD);

  always_comb
  begin
    next_st = st;
    next_st.sysref_s1 = sysref_in;
    next_st.sysref_s2 = st.sysref_s1;
    if (st.frame_cnt >= frame_last(input_clock_divide_ratio_in))
    begin
      next_st.frame_cnt = '0;
    end
    else
    begin
      next_st.frame_cnt = st.frame_cnt + 2'h1;
    end
    if (tick)
    begin
      next_st.line = {st.line[`ORSA_ASSERT_FRAMES-3:0], sample_over_range_in};
      case (st.flag_st)
        orsa_pkg::ORSA_FLAG_CLEAR:
        begin
          if (tail)
          begin
            next_st.flag_st = orsa_pkg::ORSA_FLAG_HELD;
            next_st.rel_cnt = release_delay_in;
          end
        end
        orsa_pkg::ORSA_FLAG_HELD:
        begin
          if (tail)
          begin
            next_st.rel_cnt = release_delay_in;
          end
          else if (st.rel_cnt == '0)
          begin
            next_st.flag_st = orsa_pkg::ORSA_FLAG_CLEAR;
          end
          else
          begin
            next_st.rel_cnt = st.rel_cnt - 1'b1;
          end
        end
        default:
        begin
          next_st.flag_st = orsa_pkg::ORSA_FLAG_CLEAR;
        end
      endcase
    end
    if (overrange_mode_in)
    begin
      next_st.pin_oe = 1'b1;
      next_st.pin_out = (next_st.flag_st == orsa_pkg::ORSA_FLAG_HELD);
    end
    else
    begin
      next_st.pin_oe = readback_active_in;
      next_st.pin_out = readback_active_in & readback_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st <= '{frame_cnt: '0, line: '0, flag_st: orsa_pkg::ORSA_FLAG_CLEAR, rel_cnt: '0,
              sysref_s1: 1'b0, sysref_s2: 1'b0, pin_out: 1'b0, pin_oe: 1'b0};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign align_link.ratio = input_clock_divide_ratio_in;
  assign align_link.sysref_sync = st.sysref_s2;

  orsa_sysref_align u_align (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .link(align_link)
  );

  // one-hot held bit, straight from the state register
  assign over_range_flag_out = st.flag_st[1];
  assign shared_readback_overrange_pin_out = st.pin_out;
  assign shared_readback_overrange_pin_oe_out = st.pin_oe;
  assign lmfc_boundary_out = align_link.lmfc_pulse;

  chk_flag_assert_delay: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (input_clock_divide_ratio_in == `ORSA_DIV1 && overrange_mode_in && sample_over_range_in)
      |-> ##8 shared_readback_overrange_pin_out)
    else $error("flag not raised 8 frames after over-range sample");

  chk_release_load: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (tick && tail) |=> (held && st.rel_cnt == $past(release_delay_in)))
    else $error("release delay not loaded from setting");

  chk_release_min: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (input_clock_divide_ratio_in == `ORSA_DIV1 && release_delay_in == '0 && overrange_mode_in
      && $past(sample_over_range_in) && !sample_over_range_in)
      ##1 (!sample_over_range_in && release_delay_in == '0 && overrange_mode_in) [*8]
      |-> !shared_readback_overrange_pin_out && $past(shared_readback_overrange_pin_out))
    else $error("flag release at minimum setting off time");

  chk_release_count: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (tick && held && !tail && st.rel_cnt != '0) |=> (held && st.rel_cnt == $past(st.rel_cnt) - 1'b1))
    else $error("release countdown wrong");

  chk_pin_mode: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    overrange_mode_in |=> (shared_readback_overrange_pin_oe_out
      && shared_readback_overrange_pin_out == over_range_flag_out))
    else $error("pin not carrying flag in over-range mode");

  chk_lmfc_div1: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (input_clock_divide_ratio_in == `ORSA_DIV1 && $rose(sysref_in))
      ##1 (input_clock_divide_ratio_in == `ORSA_DIV1) [*3] |=> lmfc_boundary_out)
    else $error("boundary not 4 clocks after reference");

  chk_frame_div1: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (input_clock_divide_ratio_in == `ORSA_DIV1) [*2] |-> tick)
    else $error("frame tick missing at divide by one");

  chk_pin_hiz: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!overrange_mode_in && !readback_active_in) |=> !shared_readback_overrange_pin_oe_out)
    else $error("pin driven outside read");

  chk_flag_restart: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (tick && held && tail) |=> held)
    else $error("flag dropped during over-range");

  chk_flag_source: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!held && !(tick && tail)) |=> !held)
    else $error("flag raised without delayed over-range sample");

  chk_release_done: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (tick && held && !tail && st.rel_cnt == '0) |=> !held)
    else $error("flag not released at end of countdown");

  chk_pin_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!overrange_mode_in && readback_active_in) |=> (shared_readback_overrange_pin_oe_out
      && shared_readback_overrange_pin_out == $past(readback_data_in)))
    else $error("pin not driving readback during read");

  chk_frame_div2: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (input_clock_divide_ratio_in == `ORSA_DIV2 && tick)
      ##1 (input_clock_divide_ratio_in == `ORSA_DIV2)
      |-> !tick ##1 tick)
    else $error("frame tick not every second clock");

  chk_frame_div4: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (input_clock_divide_ratio_in == `ORSA_DIV4 && tick)
      ##1 (input_clock_divide_ratio_in == `ORSA_DIV4) [*3]
      |-> (!tick && !$past(tick) && !$past(tick, 2)) ##1 tick)
    else $error("frame tick not every fourth clock");
endmodule

`default_nettype wire

// ### sim/orsa_partner.sv
`timescale 1ns/10ps
`default_nettype none

module orsa_partner (
  input wire logic clk_in,
  output logic sysref_out
);
  initial
  begin
    sysref_out = 1'b0;
  end

  // one reference pulse, caller enters just after a rising edge
  task automatic send(input int frame_cycles);
    sysref_out <= 1'b1;
    repeat (2 * frame_cycles) @(posedge clk_in);
    sysref_out <= 1'b0;
    repeat (2 * frame_cycles) @(posedge clk_in);
  endtask
endmodule

`default_nettype wire

// ### sim/orsa_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "orsa_defines.svh"

module orsa_top_tb;
  logic clk_in;
  logic rst_n_in;
  logic [1:0] ratio;
  logic over_range_flag;
  logic [`ORSA_REL_W-1:0] rel;
  logic mode;
  logic rb_act;
  logic rb_data;
  wire logic sysref;
  logic flag;
  logic pin;
  logic pin_oe;
  logic lmfc;
  int n_fail;
  int n_compared;

  orsa_top orsa_top_inst (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .input_clock_divide_ratio_in(ratio),
    .sample_over_range_in(over_range_flag),
    .release_delay_in(rel),
    .overrange_mode_in(mode),
    .readback_active_in(rb_act),
    .readback_data_in(rb_data),
    .sysref_in(sysref),
    .over_range_flag_out(flag),
    .shared_readback_overrange_pin_out(pin),
    .shared_readback_overrange_pin_oe_out(pin_oe),
    .lmfc_boundary_out(lmfc)
  );

  orsa_partner orsa_partner_inst (
    .clk_in(clk_in),
    .sysref_out(sysref)
  );

  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task automatic check(input logic seen, input logic exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic check_pin(input logic f);
    if (mode)
    begin
      check(pin_oe, 1'b1);
      check(pin, f);
    end
    else
    begin
      check(pin_oe, rb_act);
      check(pin, rb_act & rb_data);
    end
  endtask

  task automatic set_pins(input logic m, input logic a, input logic b);
    @(posedge clk_in);
    mode <= m;
    rb_act <= a;
    rb_data <= b;
    repeat (3) @(posedge clk_in);
  endtask

  // len out-of-range samples at divide-by-one, then in range
  task automatic ovr_burst(input int len, input logic [`ORSA_REL_W-1:0] d);
    logic e;
    @(posedge clk_in);
    rel <= d;
    over_range_flag <= 1'b1;
    for (int k = 0; k < len + 28; k++)
    begin
      @(posedge clk_in);
      over_range_flag <= (k + 1 < len);
      #1;
      e = (k >= `ORSA_ASSERT_FRAMES - 1) && (k < len + `ORSA_ASSERT_FRAMES - 1 + int'(d));
      check(flag, e);
      check_pin(e);
    end
  endtask

  task automatic sysref_case(input logic [1:0] code, input int fc, input int dly);
    @(posedge clk_in);
    ratio <= code;
    repeat (8) @(posedge clk_in);
    fork
      orsa_partner_inst.send(fc);
      for (int k = 0; k < dly + 3; k++)
      begin
        @(posedge clk_in);
        #1;
        check(lmfc, k == dly - 1);
      end
    join
  endtask

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    repeat (3000) @(posedge clk_in);
    n_fail++;
    finish_test();
  end

  initial
  begin
    rst_n_in = 1'b0;
    ratio = 2'h0;
    over_range_flag = 1'b0;
    rel = '0;
    mode = 1'b1;
    rb_act = 1'b0;
    rb_data = 1'b0;
    n_fail = 0;
    n_compared = 0;
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    ovr_burst(1, 4'h0);
    ovr_burst(1, 4'hf);
    ovr_burst(3, 4'h5);
    ovr_burst(2, 4'h0);
    set_pins(1'b0, 1'b0, 1'b1);
    ovr_burst(1, 4'h0);
    set_pins(1'b0, 1'b1, 1'b1);
    ovr_burst(2, 4'h3);
    set_pins(1'b0, 1'b1, 1'b0);
    ovr_burst(1, 4'h1);
    sysref_case(2'h0, 1, 4);
    sysref_case(2'h1, 2, 10);
    sysref_case(2'h2, 4, 18);
    sysref_case(2'h3, 4, 18);
    finish_test();
  end
endmodule

`default_nettype wire
